// ---- verilog/sfc_defines.svh ----
// Purpose: Named constants of the switch configuration serial port.
// Assumes: Included by its bare name wherever a field or code is needed.
// Notes:   Definitions only.
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define WORD_W          16
`define CNT_W           4
`define WDIN_BIT        15
`define SEL_HI          14
`define SEL_LO          13
`define ADDR_HI         12
`define ADDR_LO         10
`define DATA_HI         8
`define SOA_HI          4
`define NORMAL_MODE     1'b1
`define SEL_ZERO        2'h0

// ----------------------------------------------------------------------
// Register addresses and read-back codes
// ----------------------------------------------------------------------
`define ADDR_STATUS     3'h0
`define ADDR_FAULT_MGMT 3'h3
`define ADDR_OVERCUR    3'h4
`define ADDR_GLOBAL     3'h5
`define ADDR_CALIB      3'h7
`define CFG_RESET       9'h000
`define FM_WRITE_MASK   9'h07f
`define GC_WRITE_MASK   9'h1fd

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FM_RETRY_UNLIM  6
`define FM_RETRY_DIS    5
`define FM_SHORT_OFF    4
`define FM_OLON_OFF     3
`define FM_OLOFF_OFF    2
`define FM_LED_SEL      1
`define FM_RATIO        0
`define OC_DISCHARGE    8
`define OC_COOL_HI      7
`define OC_COOL_LO      6
`define OC_INRUSH_HI    5
`define OC_INRUSH_LO    4
`define OC_SWAP         3
`define OC_STEADY_HI    2
`define OC_STEADY_LO    1
`define OC_MODE         0
`define GC_SUPPLY_FAIL  8
`define GC_PULSE_EN     7
`define GC_CLK_SEL      6
`define GC_TEMP         5
`define GC_MIRROR       4
`define GC_CH_HI        3
`define GC_CH_LO        2
`define GC_OV_OFF       0

`endif

// ---- verilog/sfc_pkg.sv ----
// Purpose: Types shared by the switch configuration serial port.
// Assumes: Constants come from sfc_defines.svh.
// Notes:   Decoded settings travel as packed structs.
package sfc_pkg;

  // ----------------------------------------------------------------------
  // Setting encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {COOL_MEDIUM, COOL_SLOW, COOL_FAST} cool_speed_e;
  typedef enum logic [1:0] {INRUSH_SLOW, INRUSH_FAST, INRUSH_MEDIUM, INRUSH_VERY_SLOW} inrush_speed_e;
  typedef enum logic [1:0] {STEADY_L1, STEADY_L2, STEADY_L3, STEADY_L4} steady_level_e;
  typedef enum logic [1:0] {OLON_BULB, OLON_LED, OLON_OFF} on_openload_e;
  typedef enum logic [1:0] {PCLK_NONE, PCLK_EXT, PCLK_INT} pulse_clock_e;
  typedef enum logic [1:0] {FB_HIZ, FB_MIRROR, FB_TEMP} feedback_e;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic          retry_counter_off;
    logic          retry_off;
    logic          supply_short_protect_off;
    logic          off_state_openload_off;
    on_openload_e  on_openload;
    logic          sense_ratio_high;
    logic          discharge_profile;
    cool_speed_e   cooling_speed;
    inrush_speed_e inrush_speed;
    logic          high_level_swap;
    steady_level_e steady_limit;
    logic          overcurrent_mode_sel;
  } chan_cfg_s;

  typedef struct packed {
    logic         supply_fail_detect_en;
    logic         pulse_module_en;
    pulse_clock_e pulse_clock;
    feedback_e    feedback;
    logic [1:0]   mirror_channel;
    logic         overvoltage_protect_off;
  } glob_cfg_s;

  typedef struct packed {
    logic [3:0] direct_in;
    logic       sclk;
    logic       cs_b;
    logic       si;
  } pins_s;

  typedef struct packed {
    logic             cs_b;
    logic             sclk;
    logic [15:0]      in_sr;
    logic [15:0]      out_sr;
    logic [3:0]       bit_cnt;
    logic             got_bits;
    logic             so_oe;
    logic             so_d;
    logic [3:0][8:0]  fault_mgmt;
    logic [3:0][8:0]  overcurrent;
    logic [8:0]       global_cfg;
    logic [4:0]       readback_sel;
    logic             wdin_last;
    logic             rearm;
    logic             cal_strobe;
    logic [8:0]       cal_data;
  } state_s;

endpackage : sfc_pkg

// ---- verilog/pin_sync.sv ----
// Purpose: Two-stage synchroniser for pins from outside the mclk domain.
// Assumes: Inputs are slow levels or a serial clock well below mclk.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // Pins and synchronised copy
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // Both stages reset low; a high pin shows after two edges
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : pin_sync

`default_nettype wire

// ---- verilog/chan_cfg_decode.sv ----
// Purpose: Turns one output's two configuration words into settings.
// Assumes: Words come straight from the register file.
// Notes:   Purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "sfc_defines.svh"

module chan_cfg_decode
  import sfc_pkg::*;
(
  // Stored words
  input  wire logic [8:0] fault_mgmt,
  input  wire logic [8:0] overcurrent,
  // Decoded settings
  output chan_cfg_s       cfg
);

  // Field decode of both words
  always_comb begin
    cfg = '0;
    cfg.retry_counter_off        = fault_mgmt[`FM_RETRY_UNLIM];
    cfg.retry_off                = fault_mgmt[`FM_RETRY_DIS];
    cfg.supply_short_protect_off = fault_mgmt[`FM_SHORT_OFF];
    cfg.off_state_openload_off   = fault_mgmt[`FM_OLOFF_OFF];
    // Disable wins over the threshold choice
    if (fault_mgmt[`FM_OLON_OFF])
      cfg.on_openload = OLON_OFF;
    else if (fault_mgmt[`FM_LED_SEL])
      cfg.on_openload = OLON_LED;
    else
      cfg.on_openload = OLON_BULB;
    cfg.sense_ratio_high  = fault_mgmt[`FM_RATIO];
    cfg.discharge_profile = overcurrent[`OC_DISCHARGE];
    unique case (overcurrent[`OC_COOL_HI:`OC_COOL_LO])
      2'h1:    cfg.cooling_speed = COOL_SLOW;
      2'h2:    cfg.cooling_speed = COOL_FAST;
      default: cfg.cooling_speed = COOL_MEDIUM;
    endcase
    unique case (overcurrent[`OC_INRUSH_HI:`OC_INRUSH_LO])
      2'h0: cfg.inrush_speed = INRUSH_SLOW;
      2'h1: cfg.inrush_speed = INRUSH_FAST;
      2'h2: cfg.inrush_speed = INRUSH_MEDIUM;
      2'h3: cfg.inrush_speed = INRUSH_VERY_SLOW;
    endcase
    cfg.high_level_swap = overcurrent[`OC_SWAP];
    unique case (overcurrent[`OC_STEADY_HI:`OC_STEADY_LO])
      2'h0: cfg.steady_limit = STEADY_L2;
      2'h1: cfg.steady_limit = STEADY_L3;
      2'h2: cfg.steady_limit = STEADY_L4;
      2'h3: cfg.steady_limit = STEADY_L1;
    endcase
    cfg.overcurrent_mode_sel = overcurrent[`OC_MODE];
  end

endmodule : chan_cfg_decode

`default_nettype wire

// ---- verilog/switch_fault_config_serial_port.sv ----
// Purpose: Serial-port register logic of a four-output protected switch.
// Assumes: Host drives 16-bit words, SI sampled on sclk rising, SO moves on falling.
// Notes:   Pins are sampled by mclk; sclk must stay well below mclk / 4.
`timescale 1ns/100ps
`default_nettype none
`include "sfc_defines.svh"

// Functional notes
// - Per-output writes go only to the output picked by D14:D13.
// - Unlimited-retry bit set disables that output's retry counter.
// - Retry-disable bit set stops automatic retry on that output.
// - D4 disables supply-short protection, D2 disables off-state open-load.
// - D3 disables on-state open-load; else D1 picks LED or bulb threshold.
// - D0 picks high or low current-sense ratio for that output.
// - Overcurrent D8 selects discharge-lamp profile over bulb profile.
// - Cooling speed: 00 medium, 01 slow, 10 fast, 11 medium.
// - Inrush speed: 00 slow, 01 fast, 10 medium, 11 very slow.
// - D3 swaps in second high level during first overcurrent window.
// - Steady limit: 00 level two, 01 three, 10 four, 11 one.
// - D0 chooses inrush-only or inrush plus cooling management.
// - Global D8 enables fail-safe entry on logic supply failure.
// - Global D7 drives outputs from pulse registers, ignoring direct inputs.
// - With pulse module on, D6 picks internal or input-zero clock.
// - Feedback: 00 hi-Z, D4 mirrors output D3:D2, 10 temperature.
// - Global D0 set disables overvoltage protection.
// - Chip select fall loads output word, shifted out MSB first.
// - After 16 bits, received input bits are echoed for daisy chains.
// - Chip select rise tri-states SO; only whole-word frames are latched and re-arm faults.
// - Latest status write selects returned content and output until replaced.
// - An invalid frame leaves returned status unchanged.
// - D12:D10 address; D14:D13 select output, zero for global and calibration.
module switch_fault_config_serial_port
  import sfc_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // Serial port pins
  input  wire logic              sclk,
  input  wire logic              cs_b,
  input  wire logic              si,
  output logic                   so_out,
  output logic                   so_oe,
  // Direct control inputs and pulse-module drive
  input  wire logic [3:0]        direct_in,
  input  wire logic [3:0]        pulse_drive,
  output logic      [3:0]        switch_cmd,
  // Fault status from the protection logic
  input  wire logic [3:0][7:0]   fault_status,
  input  wire logic              power_on_seen,
  output logic                   fault_rearm,
  // Calibration register write
  output logic                   cal_strobe,
  output logic      [8:0]        cal_data,
  // Decoded settings
  output chan_cfg_s [3:0]        chan_cfg,
  output glob_cfg_s              glob_cfg,
  output logic                   analog_feedback_pin_oe,
  output logic                   pulse_ref_from_input_zero
);

  // ----------------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------------
  pins_s  pins_raw;
  pins_s  pins;
  state_s state_reg;
  state_s state_next;

  // Every pin is asynchronous to mclk
  assign pins_raw.direct_in = direct_in;
  assign pins_raw.sclk      = sclk;
  assign pins_raw.cs_b      = cs_b;
  assign pins_raw.si        = si;

  pin_sync #(
    .WIDTH ($bits(pins_s))
  ) u_pin_sync (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .async_in (pins_raw),
    .sync_out (pins)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Word returned in the next frame, built when chip select falls
  function automatic logic [15:0] return_word(input state_s s,
                                              input logic [3:0][7:0] flt,
                                              input logic por);
    logic [8:0] content;
    logic [1:0] ch;
    content = '0;
    ch      = s.readback_sel[`SOA_HI:`SOA_HI-1];
    unique case (s.readback_sel[2:0])
      `ADDR_STATUS:     content = {por, flt[ch]};
      `ADDR_FAULT_MGMT: content = s.fault_mgmt[ch];
      `ADDR_OVERCUR:    content = s.overcurrent[ch];
      `ADDR_GLOBAL:     content = s.global_cfg;
      default:          content = '0;
    endcase
    return_word = {s.wdin_last, s.readback_sel, `NORMAL_MODE, content};
  endfunction : return_word

  // Frame is whole words only; an empty frame carries nothing
  function automatic logic frame_valid(input state_s s);
    frame_valid = s.got_bits && (s.bit_cnt == '0);
  endfunction : frame_valid

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  logic       cs_fall;
  logic       cs_rise;
  logic       sclk_rise;
  logic       sclk_fall;
  logic [2:0] addr;
  logic [1:0] sel;
  logic [8:0] wdata;

  // Edges compare the synchronised copy with its last value
  assign cs_fall   = state_reg.cs_b && !pins.cs_b;
  assign cs_rise   = !state_reg.cs_b && pins.cs_b;
  assign sclk_rise = !pins.cs_b && !state_reg.sclk && pins.sclk;
  assign sclk_fall = !pins.cs_b && state_reg.sclk && !pins.sclk;

  // Fields of the word just received
  assign addr  = state_reg.in_sr[`ADDR_HI:`ADDR_LO];
  assign sel   = state_reg.in_sr[`SEL_HI:`SEL_LO];
  assign wdata = state_reg.in_sr[`DATA_HI:0];

  always_comb begin
    state_next            = state_reg;
    state_next.cs_b       = pins.cs_b;
    state_next.sclk       = pins.sclk;
    state_next.rearm      = 1'b0;
    state_next.cal_strobe = 1'b0;

    // Frame opens: capture the return word, drive its MSB at once
    if (cs_fall) begin
      state_next.out_sr   = return_word(state_reg, fault_status, power_on_seen);
      state_next.so_d     = state_next.out_sr[`WORD_W-1];
      state_next.so_oe    = 1'b1;
      state_next.bit_cnt  = '0;
      state_next.got_bits = 1'b0;
    end

    // Input side: one bit per sclk rise
    if (sclk_rise) begin
      state_next.in_sr    = {state_reg.in_sr[`WORD_W-2:0], pins.si};
      state_next.bit_cnt  = state_reg.bit_cnt + 1'b1;
      state_next.got_bits = 1'b1;
    end

    // Output side: the received stream follows the first 16 bits out
    if (sclk_fall) begin
      state_next.out_sr = {state_reg.out_sr[`WORD_W-2:0], state_reg.in_sr[0]};
      state_next.so_d   = state_reg.out_sr[`WORD_W-2];
    end

    // Frame closes: hi-Z first, then latch only whole words
    if (cs_rise) begin
      state_next.so_oe = 1'b0;
      if (frame_valid(state_reg)) begin
        state_next.rearm     = 1'b1;
        state_next.wdin_last = state_reg.in_sr[`WDIN_BIT];
        unique case (addr)
          `ADDR_STATUS:
            state_next.readback_sel = state_reg.in_sr[`SOA_HI:0];
          `ADDR_FAULT_MGMT:
            state_next.fault_mgmt[sel] = wdata & `FM_WRITE_MASK;
          `ADDR_OVERCUR:
            state_next.overcurrent[sel] = wdata;
          `ADDR_GLOBAL:
            if (sel == `SEL_ZERO)
              state_next.global_cfg = wdata & `GC_WRITE_MASK;
          `ADDR_CALIB:
            if (sel == `SEL_ZERO) begin
              state_next.cal_strobe = 1'b1;
              state_next.cal_data   = wdata;
            end
          default: ;
        endcase
      end
      // A frame that is not a multiple of 16 bits falls through here untouched
    end

    // Closed frame keeps SO off whatever else happened
    if (pins.cs_b && !cs_rise)
      state_next.so_oe = 1'b0;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Edge history resets low like the synchroniser, so no false select follows reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg              <= '0;
      state_reg.fault_mgmt   <= {4{`CFG_RESET}};
      state_reg.overcurrent  <= {4{`CFG_RESET}};
      state_reg.global_cfg   <= `CFG_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Serial output and strobes
  // ----------------------------------------------------------------------
  assign so_out      = state_reg.so_d;
  assign so_oe       = state_reg.so_oe;
  assign fault_rearm = state_reg.rearm;
  assign cal_strobe  = state_reg.cal_strobe;
  assign cal_data    = state_reg.cal_data;

  // ----------------------------------------------------------------------
  // Per-output settings
  // ----------------------------------------------------------------------
  for (genvar ch = 0; ch < 4; ch++) begin : g_chan
    chan_cfg_decode u_decode (
      .fault_mgmt  (state_reg.fault_mgmt[ch]),
      .overcurrent (state_reg.overcurrent[ch]),
      .cfg         (chan_cfg[ch])
    );
  end

  // ----------------------------------------------------------------------
  // Global settings
  // ----------------------------------------------------------------------
  logic [8:0] global_configuration;
  assign global_configuration = state_reg.global_cfg;

  // Field decode; clock choice is moot while the module is off
  always_comb begin
    glob_cfg = '0;
    glob_cfg.supply_fail_detect_en   = global_configuration[`GC_SUPPLY_FAIL];
    glob_cfg.pulse_module_en         = global_configuration[`GC_PULSE_EN];
    if (!global_configuration[`GC_PULSE_EN])
      glob_cfg.pulse_clock = PCLK_NONE;
    else if (global_configuration[`GC_CLK_SEL])
      glob_cfg.pulse_clock = PCLK_INT;
    else
      glob_cfg.pulse_clock = PCLK_EXT;
    // Mirror wins over temperature when both are set
    if (global_configuration[`GC_MIRROR])
      glob_cfg.feedback = FB_MIRROR;
    else if (global_configuration[`GC_TEMP])
      glob_cfg.feedback = FB_TEMP;
    else
      glob_cfg.feedback = FB_HIZ;
    glob_cfg.mirror_channel          = global_configuration[`GC_CH_HI:`GC_CH_LO];
    glob_cfg.overvoltage_protect_off = global_configuration[`GC_OV_OFF];
  end

  // Feedback pin driven only when something is reported
  assign analog_feedback_pin_oe    = (glob_cfg.feedback != FB_HIZ);
  assign pulse_ref_from_input_zero = (glob_cfg.pulse_clock == PCLK_EXT);

  // Pulse module overrides the direct inputs completely
  assign switch_cmd = global_configuration[`GC_PULSE_EN] ? pulse_drive : pins.direct_in;

endmodule : switch_fault_config_serial_port

`default_nettype wire

// ---- bench/sfc_checker_properties.sv ----
// Purpose: Port-level checks of the switch configuration serial port.
// Assumes: One mclk domain, reset rst_b active low.
// Notes:   Attached by bind at the foot of this file.
`timescale 1ns/100ps
`default_nettype none

module sfc_checker
  import sfc_pkg::*;
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_b,
  // Watched ports
  input wire logic       cs_b,
  input wire logic       so_oe,
  input wire logic       fault_rearm,
  input wire logic       cal_strobe,
  input wire logic [3:0] switch_cmd,
  input wire logic [3:0] pulse_drive,
  input wire glob_cfg_s  glob_cfg,
  input wire logic       analog_feedback_pin_oe,
  input wire logic       pulse_ref_from_input_zero
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // Four samples high covers the two-stage sync plus output register
  a_so_idle_hiz: assert property (cs_b [*4] |-> !so_oe)
    else $error("so driven while deselected");
  a_oe_after_fall: assert property ($fell(cs_b) |-> ##[2:4] so_oe)
    else $error("so not enabled after select");
  a_rearm_single: assert property (fault_rearm |=> !fault_rearm)
    else $error("rearm longer than one cycle");
  a_rearm_closed: assert property (fault_rearm |-> cs_b && !so_oe)
    else $error("rearm inside a frame");
  a_cal_in_close: assert property (cal_strobe |-> fault_rearm)
    else $error("calibration strobe without valid frame");
  a_cfg_at_close: assert property ($changed(glob_cfg) |-> cs_b && !so_oe)
    else $error("global settings moved inside a frame");
  a_pulse_drive: assert property (glob_cfg.pulse_module_en |-> switch_cmd == pulse_drive)
    else $error("outputs not taken from pulse module");
  a_fb_enable: assert property (analog_feedback_pin_oe == (glob_cfg.feedback != FB_HIZ))
    else $error("feedback enable disagrees with mode");
  a_ext_clock_ref: assert property (pulse_ref_from_input_zero ==
    (glob_cfg.pulse_module_en && glob_cfg.pulse_clock == PCLK_EXT))
    else $error("pulse reference choice wrong");

  c_rearm: cover property (fault_rearm);
  c_cal: cover property (cal_strobe);
  c_pulse_frame: cover property (glob_cfg.pulse_module_en && so_oe);
endmodule : sfc_checker

bind switch_fault_config_serial_port sfc_checker u_sfc_checker (.mclk(mclk), .rst_b(rst_b), .cs_b(cs_b),
  .so_oe(so_oe), .fault_rearm(fault_rearm), .cal_strobe(cal_strobe), .switch_cmd(switch_cmd),
  .pulse_drive(pulse_drive), .glob_cfg(glob_cfg), .analog_feedback_pin_oe(analog_feedback_pin_oe),
  .pulse_ref_from_input_zero(pulse_ref_from_input_zero));
`default_nettype wire

// ---- bench/host_spi.sv ----
// Purpose: Host serial master model, mode 0, MSB first.
// Assumes: Serial clock period 125 ns, free of mclk phase.
// Notes:   Unselected SO reads back unknown so it never matches.
`timescale 1ns/100ps
`default_nettype none

module host_spi (
  // Serial pins
  output logic      sclk,
  output logic      cs_b,
  output logic      si,
  input  wire logic so_out,
  input  wire logic so_oe
);
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    si   = 1'b0;
  end

  // One framed transfer of n bits; clock stands still outside frames
  task automatic frame(input logic [31:0] w, input int n, output logic [31:0] r);
    r = '0;
    #100 cs_b <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si <= w[i];
      #62.5 sclk <= 1'b1;
      r = {r[30:0], so_oe ? so_out : 1'bx};
      #62.5 sclk <= 1'b0;
    end
    #62.5 cs_b <= 1'b1;
    si <= ~si; // Released line shows no stale level
    #100;
  endtask : frame
endmodule : host_spi
`default_nettype wire

// ---- bench/switch_fault_config_serial_port_bench.sv ----
// Purpose: Self-checking bench of the switch configuration serial port.
// Assumes: Host model drives the serial pins; bench drives the rest.
// Notes:   Readback goes through status-select writes.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module switch_fault_config_serial_port_bench;
  import sfc_pkg::*;
  typedef struct packed {logic [15:0] wr; logic [4:0] sel; logic [8:0] exp;} row_s;
  logic            mclk, rst_b, sclk, cs_b, si, so_out, so_oe, fault_rearm, cal_strobe, fb_oe, ref0, pwr;
  logic [3:0]      direct_in, pulse_drive, switch_cmd;
  logic [3:0][7:0] fault_status;
  logic [8:0]      cal_data;
  chan_cfg_s [3:0] chan_cfg;
  glob_cfg_s       glob_cfg;
  logic [31:0]     r;
  int              num_errors, n_tests, cyc, rearms, r0, cals;
  row_s rows [6] = '{
    '{16'h4dff, 5'h13, 9'h07f},
    '{16'h315a, 5'h0c, 9'h15a},
    '{16'h15ff, 5'h05, 9'h1fd},
    '{16'h3400, 5'h05, 9'h1fd},
    '{16'h0003, 5'h03, 9'h000},
    '{16'h0010, 5'h10, 9'h15a}};

  switch_fault_config_serial_port u_switch_fault_config_serial_port (.mclk(mclk), .rst_b(rst_b),
    .sclk(sclk), .cs_b(cs_b), .si(si), .so_out(so_out), .so_oe(so_oe), .direct_in(direct_in),
    .pulse_drive(pulse_drive), .switch_cmd(switch_cmd), .fault_status(fault_status),
    .power_on_seen(pwr), .fault_rearm(fault_rearm), .cal_strobe(cal_strobe), .cal_data(cal_data),
    .chan_cfg(chan_cfg), .glob_cfg(glob_cfg), .analog_feedback_pin_oe(fb_oe),
    .pulse_ref_from_input_zero(ref0));
  host_spi u_host_spi (.sclk(sclk), .cs_b(cs_b), .si(si), .so_out(so_out), .so_oe(so_oe));

  // ----------------------------------------------------------------------
  // Clock, cycle ceiling and rearm count
  // ----------------------------------------------------------------------
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (fault_rearm === 1'b1) rearms++;
    if (cal_strobe === 1'b1) cals++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // Select, then read back on the following frame
  task automatic check_sel(input logic [4:0] sel, input logic [8:0] e);
    u_host_spi.frame({27'h0, sel}, 16, r);
    u_host_spi.frame({27'h0, sel}, 16, r);
    `CHK("readback", {1'b0, sel, 1'b1, e}, r[15:0])
  endtask : check_sel

  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    direct_in = 4'h5;
    pulse_drive = 4'ha;
    fault_status = 32'h005a_0000;
    pwr = 1'b1;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK("so_oe idle", 1'b0, so_oe)
    `CHK("glob reset", 9'h000, glob_cfg)
    check_sel(5'h05, 9'h000);
    foreach (rows[i]) begin
      u_host_spi.frame({16'h0, rows[i].wr}, 16, r);
      check_sel(rows[i].sel, rows[i].exp);
    end
    `CHK("retry ctr", 1'b1, chan_cfg[2].retry_counter_off)
    `CHK("olon", OLON_OFF, chan_cfg[2].on_openload)
    `CHK("cool", COOL_SLOW, chan_cfg[1].cooling_speed)
    `CHK("inrush", INRUSH_FAST, chan_cfg[1].inrush_speed)
    `CHK("steady", STEADY_L3, chan_cfg[1].steady_limit)
    `CHK("pclk", PCLK_INT, glob_cfg.pulse_clock)
    `CHK("fb", FB_MIRROR, glob_cfg.feedback)
    `CHK("supply", 1'b1, glob_cfg.supply_fail_detect_en)
    `CHK("switch", pulse_drive, switch_cmd)
    `CHK("ratio", 1'b1, chan_cfg[2].sense_ratio_high)
    `CHK("short off", 1'b1, chan_cfg[2].supply_short_protect_off)
    `CHK("oloff off", 1'b1, chan_cfg[2].off_state_openload_off)
    `CHK("retry off", 1'b1, chan_cfg[2].retry_off)
    `CHK("discharge", 1'b1, chan_cfg[1].discharge_profile)
    `CHK("swap", 1'b1, chan_cfg[1].high_level_swap)
    `CHK("oc mode", 1'b0, chan_cfg[1].overcurrent_mode_sel)
    `CHK("mirror ch", 2'h3, glob_cfg.mirror_channel)
    `CHK("fb oe on", 1'b1, fb_oe)
    `CHK("ref0 int", 1'b0, ref0)
    `CHK("ov off", 1'b1, glob_cfg.overvoltage_protect_off)
    u_host_spi.frame({16'ha5c3, 16'h0005}, 32, r);
    `CHK("first word", {1'b0, 5'h10, 1'b1, 9'h15a}, r[31:16])
    `CHK("echo", 16'ha5c3, r[15:0])
    u_host_spi.frame(32'h0005, 16, r);
    r0 = rearms;
    u_host_spi.frame(32'h0094_00, 24, r);
    `CHK("rearm count", r0, rearms)
    u_host_spi.frame(32'h0005, 16, r);
    `CHK("after bad", {1'b0, 5'h05, 1'b1, 9'h1fd}, r[15:0])
    `CHK("rearm valid", r0 + 1, rearms)
    u_host_spi.frame(32'h1d6b, 16, r);
    `CHK("cal data", 9'h16b, cal_data)
    `CHK("cal strobe", 1, cals)
    u_host_spi.frame(32'h6c02, 16, r);
    `CHK("led", OLON_LED, chan_cfg[3].on_openload)
    `CHK("bulb", OLON_BULB, chan_cfg[0].on_openload)
    u_host_spi.frame(32'h14a0, 16, r);
    `CHK("ext clk", PCLK_EXT, glob_cfg.pulse_clock)
    `CHK("ref0 ext", 1'b1, ref0)
    `CHK("temp", FB_TEMP, glob_cfg.feedback)
    u_host_spi.frame(32'h1400, 16, r);
    `CHK("direct", direct_in, switch_cmd)
    `CHK("fb oe off", 1'b0, fb_oe)
    // Second reset in mid-run, then a readback through fresh synchronisers
    @(posedge mclk) rst_b <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK("retry reset", 1'b0, chan_cfg[2].retry_off)
    `CHK("so_oe reset", 1'b0, so_oe)
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    check_sel(5'h13, 9'h000);
    final_report();
  end
endmodule : switch_fault_config_serial_port_bench
`default_nettype wire
